//--- inc/esb_map.vh
// Overview of operation
// - Receive words hold line bits unaltered
// - Receive words refresh with receive align flag
// - Transmit words sampled with transmit align flag
// - Stale transmit words are resent unchanged
// - Si replaced by serial, CRC4 or E-bit
// - Sa replaced when control bits 3-7 set
// - Receive align word: Si, then pattern bits
// - Receive nonalign word: Si, marker, alarm, Sa
// - Nonalign bit 5 alarm, bits 4-0 Sa
`ifndef ESB_MAP_VH
`define ESB_MAP_VH
// ==========================================================
// Register word indices; the byte address is the index times four
`define ESB_TX_ALIGN_IDX 8'h20
`define ESB_TX_NONALIGN_IDX 8'h21
`define ESB_RX_ALIGN_IDX 8'h28
`define ESB_RX_NONALIGN_IDX 8'h29
`define ESB_CTRL_IDX 8'h30
`define ESB_STATUS_IDX 8'h31
`define ESB_CLEAR_IDX 8'h32
`define ESB_ENABLE_IDX 8'h33
// ==========================================================
// Control register fields
`define ESB_CTRL_SI_SERIAL 0
`define ESB_CTRL_CRC4 1
`define ESB_CTRL_EBIT 2
`define ESB_CTRL_SA_LO 3
`define ESB_CTRL_SA_HI 7
// ==========================================================
// Status fields and reset values
`define ESB_ST_RX_ALIGN 0
`define ESB_ST_TX_ALIGN 1
`define ESB_RST_WORD 8'h00
// ==========================================================
// Timing
`define ESB_BITS_PER_TS0 4'h8
`define ESB_HOLDOFF_US 250
`define ESB_CLK_MHZ 50
`define ESB_HOLDOFF_CYC (`ESB_HOLDOFF_US * `ESB_CLK_MHZ)
`endif

//--- hdl/esb_ts0_shift.v
`timescale 1ns/1ps
`default_nettype none
// Shifts a TS0 word out bit 7 first, one bit per strobe.
module esb_ts0_shift
(
   // Clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // Control
   input wire i_load,
   input wire [7:0] i_word,
   input wire i_bit_strobe,
   // Output
   output reg o_bit
);
   reg [7:0] shreg;
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         shreg <= 8'h00;
         o_bit <= 1'b0;
      end
      else if (i_load)
      begin
         shreg <= {i_word[6:0], 1'b0};
         o_bit <= i_word[7];
      end
      else if (i_bit_strobe)
      begin
         shreg <= {shreg[6:0], 1'b0};
         o_bit <= shreg[7];
      end
   end
endmodule // esb_ts0_shift
`default_nettype wire

//--- hdl/esb_sa_si.v
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "esb_map.vh"
module esb_sa_si
(
   // Clock and reset
   input wire i_core_clk,
   input wire i_resetn,
   // Avalon-MM slave
   input wire [9:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   // Receive line side (framer strobes, same clock)
   input wire i_rx_bit,
   input wire i_rx_bit_strobe,
   input wire i_rx_ts0_start,
   input wire i_rx_align_frame,
   // Transmit line side
   input wire i_tx_bit_strobe,
   input wire i_tx_ts0_start,
   input wire i_tx_align_frame,
   input wire i_tx_serial_si,
   input wire i_tx_sa_bit,
   // Outputs
   output reg o_tx_bit,
   output reg o_tx_valid,
   output reg o_irq
);
   // ========================================================
   // Reset synchroniser
   reg rst_meta;
   reg rst_n;
   always @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ========================================================
   // Registers
   reg [7:0] tx_align_word;
   reg [7:0] tx_nonalign_word;
   reg [7:0] rx_align_word;
   reg [7:0] rx_nonalign_word;
   reg [7:0] transmit_control_register;
   reg [1:0] irq_status;
   reg [1:0] irq_enable;
   reg [7:0] tx_align_hold;
   reg [7:0] tx_nonalign_hold;

   // ========================================================
   // Receive capture
   reg [7:0] rx_shift;
   reg [3:0] rx_cnt;
   reg rx_is_align;
   reg rx_done;
   always @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_shift <= 8'h00;
         rx_cnt <= 4'h0;
         rx_is_align <= 1'b0;
         rx_done <= 1'b0;
      end
      else
      begin
         rx_done <= 1'b0;
         if (i_rx_ts0_start)
         begin
            rx_cnt <= `ESB_BITS_PER_TS0;
            rx_is_align <= i_rx_align_frame;
         end
         else if (i_rx_bit_strobe && rx_cnt != 4'h0)
         begin
            rx_shift <= {rx_shift[6:0], i_rx_bit};
            rx_cnt <= rx_cnt - 4'h1;
            rx_done <= (rx_cnt == 4'h1);
         end
      end
   end

   // Nonalign word waits in a pending copy so that both host words
   // change together with the flag; a read between flags sees a
   // consistent pair
   reg [7:0] rx_nonalign_pend;
   always @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_align_word <= `ESB_RST_WORD;
         rx_nonalign_word <= `ESB_RST_WORD;
         rx_nonalign_pend <= `ESB_RST_WORD;
      end
      else if (rx_done)
      begin
         if (rx_is_align)
         begin
            rx_align_word <= rx_shift;
            rx_nonalign_word <= rx_nonalign_pend;
         end
         else
            rx_nonalign_pend <= rx_shift;
      end
   end
   wire rx_flag_evt = rx_done && rx_is_align;

   // ========================================================
   // Transmit sampling and insertion
   wire tx_si_over = transmit_control_register[`ESB_CTRL_SI_SERIAL] |
      transmit_control_register[`ESB_CTRL_CRC4] |
      transmit_control_register[`ESB_CTRL_EBIT];
   wire tx_sa_over = |transmit_control_register[`ESB_CTRL_SA_HI:`ESB_CTRL_SA_LO];
   wire tx_flag_evt = i_tx_ts0_start && i_tx_align_frame;
   reg tx_cur_align;
   reg [3:0] tx_cnt;
   // An align slot sends the word sampled at this very start, so the
   // shifter is loaded from the register rather than the old hold copy
   wire [7:0] tx_word = !i_tx_align_frame ? tx_nonalign_hold :
      (tx_flag_evt ? tx_align_word : tx_align_hold);
   wire tx_shift_bit;
   always @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_align_hold <= `ESB_RST_WORD;
         tx_nonalign_hold <= `ESB_RST_WORD;
         tx_cur_align <= 1'b0;
         tx_cnt <= 4'h0;
      end
      else
      begin
         if (tx_flag_evt)
         begin
            // Unchanged words simply resend old data
            tx_align_hold <= tx_align_word;
            tx_nonalign_hold <= tx_nonalign_word;
         end
         if (i_tx_ts0_start)
         begin
            tx_cur_align <= i_tx_align_frame;
            tx_cnt <= `ESB_BITS_PER_TS0;
         end
         else if (i_tx_bit_strobe && tx_cnt != 4'h0)
            tx_cnt <= tx_cnt - 4'h1;
      end
   end

   esb_ts0_shift u_shift
   (
      .i_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_load(i_tx_ts0_start),
      .i_word(tx_word),
      // Each strobe consumes the bit shown and moves to the next one
      .i_bit_strobe(i_tx_bit_strobe && tx_cnt != 4'h0),
      .o_bit(tx_shift_bit)
   );

   // Bit position within TS0: 8 = first (bit 7) .. 1 = bit 0
   wire tx_at_si = (tx_cnt == 4'h8);
   wire tx_at_sa = !tx_cur_align && (tx_cnt <= 4'h5) && (tx_cnt != 4'h0);
   always @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_tx_bit <= 1'b0;
         o_tx_valid <= 1'b0;
      end
      else
      begin
         o_tx_valid <= tx_cnt != 4'h0;
         if (tx_at_si && tx_si_over)
            o_tx_bit <= i_tx_serial_si;
         else if (tx_at_sa && tx_sa_over)
            o_tx_bit <= i_tx_sa_bit;
         else
            o_tx_bit <= tx_shift_bit;
      end
   end

   // ========================================================
   // Interrupt status: set wins over clear
   wire sel_clear = i_avs_write &&
      (i_avs_address == esb_addr(`ESB_CLEAR_IDX));
   always @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_status <= 2'b00;
         o_irq <= 1'b0;
      end
      else
      begin
         irq_status <= (irq_status &
            ~(sel_clear && !o_avs_waitrequest ? i_avs_writedata[1:0] : 2'b00))
            | {tx_flag_evt, rx_flag_evt};
         o_irq <= |(irq_status & irq_enable);
      end
   end

   // ========================================================
   // Avalon slave: one wait cycle, answer on second edge
   function [9:0] esb_addr;
      input [7:0] idx;
      begin
         esb_addr = {idx, 2'b00};
      end
   endfunction

   wire req = i_avs_read || i_avs_write;
   always @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
         tx_align_word <= `ESB_RST_WORD;
         tx_nonalign_word <= `ESB_RST_WORD;
         transmit_control_register <= 8'h00;
         irq_enable <= 2'b00;
      end
      else
      begin
         o_avs_waitrequest <= !(req && o_avs_waitrequest);
         if (req && o_avs_waitrequest)
         begin
            o_avs_readdata <= 32'h00000000;
            if (i_avs_read)
            begin
               case (i_avs_address)
                  esb_addr(`ESB_TX_ALIGN_IDX):
                     o_avs_readdata <= {24'h000000, tx_align_word};
                  esb_addr(`ESB_TX_NONALIGN_IDX):
                     o_avs_readdata <= {24'h000000, tx_nonalign_word};
                  esb_addr(`ESB_RX_ALIGN_IDX):
                     o_avs_readdata <= {24'h000000, rx_align_word};
                  esb_addr(`ESB_RX_NONALIGN_IDX):
                     o_avs_readdata <= {24'h000000, rx_nonalign_word};
                  esb_addr(`ESB_CTRL_IDX):
                     o_avs_readdata <= {24'h000000, transmit_control_register};
                  esb_addr(`ESB_STATUS_IDX):
                     o_avs_readdata <= {30'h00000000, irq_status};
                  esb_addr(`ESB_ENABLE_IDX):
                     o_avs_readdata <= {30'h00000000, irq_enable};
                  default:
                     o_avs_readdata <= 32'h00000000;
               endcase
            end
         end
         // Writes land on the answer edge, as the clear register does
         if (i_avs_write && !o_avs_waitrequest)
         begin
            case (i_avs_address)
               esb_addr(`ESB_TX_ALIGN_IDX):
                  tx_align_word <= i_avs_writedata[7:0];
               esb_addr(`ESB_TX_NONALIGN_IDX):
                  tx_nonalign_word <= i_avs_writedata[7:0];
               esb_addr(`ESB_CTRL_IDX):
                  transmit_control_register <= i_avs_writedata[7:0];
               esb_addr(`ESB_ENABLE_IDX):
                  irq_enable <= i_avs_writedata[1:0];
               default:
                  irq_enable <= irq_enable;
            endcase
         end
      end
   end
endmodule // esb_sa_si
`default_nettype wire

//--- sim/esb_sa_si_props.sv
`timescale 1ns/1ps
`default_nettype none
module esb_props
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // Watched ports
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic i_tx_bit_strobe,
   input wire logic i_tx_ts0_start,
   input wire logic o_tx_bit,
   input wire logic o_tx_valid
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   wire logic req = i_avs_read | i_avs_write;
   wire logic far = i_avs_address > 10'h0cc;
   // ==========================================================
   // Bus answer
   answer_next_a: assert property (req && o_avs_waitrequest |=>
      !o_avs_waitrequest) else $error("request not answered");
   answer_once_a: assert property (!o_avs_waitrequest |=>
      o_avs_waitrequest) else $error("answer too long");
   idle_quiet_a: assert property (!req && o_avs_waitrequest |=>
      o_avs_waitrequest) else $error("answer without request");
   upper_zero_a: assert property (!o_avs_waitrequest |->
      o_avs_readdata[31:8] == 24'h0) else $error("upper bits set");
   unmapped_zero_a: assert property (i_avs_read && o_avs_waitrequest
      && far |=> o_avs_readdata == 32'h0) else $error("unmapped data");
   data_stands_a: assert property (o_avs_waitrequest |->
      $stable(o_avs_readdata)) else $error("read data moved");
   // ==========================================================
   // Transmit slot
   tx_first_a: assert property (i_tx_ts0_start |-> ##2 o_tx_valid)
      else $error("slot not shown");
   tx_hold_a: assert property (o_tx_valid && !i_tx_bit_strobe
      && !$past(i_tx_bit_strobe) && !i_tx_ts0_start
      && !$past(i_tx_ts0_start) ##1 o_tx_valid |-> $stable(o_tx_bit))
      else $error("bit moved without strobe");
   c_read: cover property (i_avs_read && !o_avs_waitrequest);
   c_write: cover property (i_avs_write && !o_avs_waitrequest);
   c_slot: cover property (i_tx_ts0_start ##1 o_tx_valid);
endmodule // esb_props
bind esb_sa_si esb_props i_props (.i_core_clk, .i_resetn,
   .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
   .o_avs_waitrequest, .i_tx_bit_strobe, .i_tx_ts0_start,
   .o_tx_bit, .o_tx_valid);
`default_nettype wire

//--- sim/esb_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module esb_line_model
(
   // Bench control
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic i_align,
   input wire logic [7:0] i_word,
   // Line side
   input wire logic i_tx_bit,
   output logic o_rx_bit,
   output logic o_strobe,
   output logic o_ts0,
   output logic o_af,
   output logic [7:0] o_tx_word,
   output logic o_busy
);
   logic [5:0] cnt;
   initial
   begin
      {o_rx_bit, o_strobe, o_ts0, o_af, o_busy} = 5'h0;
      o_tx_word = 8'h00;
      cnt = 6'h0;
   end
   // ==========================================================
   // One slot: start pulse, then a strobe every fourth cycle
   always @(posedge i_clk)
   begin
      o_ts0 <= 1'b0;
      o_strobe <= 1'b0;
      // Between bits the data line toggles every cycle, so only the strobe marks a valid bit
      o_rx_bit <= ~o_rx_bit;
      if (i_go && !o_busy)
      begin
         o_busy <= 1'b1;
         cnt <= 6'h0;
         o_ts0 <= 1'b1;
         o_af <= i_align;
      end
      else if (o_busy)
      begin
         cnt <= cnt + 6'h1;
         if (cnt[1:0] == 2'h2 && cnt < 6'h20)
         begin
            o_strobe <= 1'b1;
            o_rx_bit <= i_word[3'h7 - cnt[4:2]];
         end
         if (o_strobe)
            o_tx_word <= {o_tx_word[6:0], i_tx_bit};
         if (cnt == 6'h22)
            o_busy <= 1'b0;
      end
   end
endmodule // esb_line_model
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic go = 1'b0;
   logic al = 1'b0;
   logic si = 1'b0;
   logic [9:0] adr = 10'h0;
   logic [31:0] wd = 32'h0;
   logic [31:0] q;
   logic [7:0] rw = 8'h00;
   logic [7:0] c;
   wire logic ws, irq, rxb, rxs, ts0, af, busy, txb, txv;
   wire logic [31:0] rdat;
   wire logic [7:0] txw;
   integer n_mismatch = 0;
   integer n_checks = 0;
   integer k;
   initial forever #10 clk = ~clk;
   esb_sa_si i_dut (.i_core_clk(clk), .i_resetn(resetn),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .o_avs_readdata(rdat),
      .o_avs_waitrequest(ws), .i_rx_bit(rxb), .i_rx_bit_strobe(rxs),
      .i_rx_ts0_start(ts0), .i_rx_align_frame(af),
      .i_tx_bit_strobe(rxs), .i_tx_ts0_start(ts0),
      .i_tx_align_frame(af), .i_tx_serial_si(si), .i_tx_sa_bit(1'b1),
      .o_tx_bit(txb), .o_tx_valid(txv), .o_irq(irq));
   esb_line_model i_line (.i_clk(clk), .i_go(go), .i_align(al),
      .i_word(rw), .i_tx_bit(txb), .o_rx_bit(rxb), .o_strobe(rxs),
      .o_ts0(ts0), .o_af(af), .o_tx_word(txw), .o_busy(busy));
   // ==========================================================
   // Shared tasks
   task conclude;
   begin
      if (n_mismatch == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   task check(input logic [7:0] s, input logic [7:0] e);
   begin
      n_checks = n_checks + 1;
      if (s !== e)
      begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   end
   endtask
   // A wait that runs out counts as a mismatch and ends the run
   task expire;
   begin
      n_mismatch = n_mismatch + 1;
      conclude;
   end
   endtask
   // Request holds until the edge at which waitrequest is seen low
   task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      integer n;
   begin
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      n = 0;
      @(posedge clk);
      while (ws !== 1'b0 && n < 100)
      begin
         @(posedge clk);
         n = n + 1;
      end
      if (n == 100)
         expire;
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   end
   endtask
   task get(input logic [9:0] a, input logic [7:0] e);
   begin
      bus(1'b0, a, 32'h0);
      check(q[7:0], e);
   end
   endtask
   task frame(input logic a, input logic [7:0] w);
      integer n;
   begin
      @(posedge clk);
      go <= 1'b1;
      al <= a;
      rw <= w;
      @(posedge clk);
      go <= 1'b0;
      // Busy rises at this edge, so it is first seen at the next one
      @(posedge clk);
      n = 0;
      while (busy !== 1'b0 && n < 100)
      begin
         @(posedge clk);
         n = n + 1;
      end
      if (n == 100)
         expire;
   end
   endtask
   task irq_is(input logic e);
   begin
      repeat (2) @(posedge clk);
      check({7'h0, irq}, {7'h0, e});
   end
   endtask
   // ==========================================================
   // Scenarios
   task t_regs;
   begin
      get(10'h0a4, 8'h00);
      bus(1'b1, 10'h0a0, 32'hff);
      get(10'h0a0, 8'h00);
      bus(1'b1, 10'h3fc, 32'h55);
      get(10'h3fc, 8'h00);
   end
   endtask
   task t_rx;
   begin
      frame(1'b0, 8'hd5);
      frame(1'b1, 8'h1b);
      get(10'h0c4, 8'h03);
      get(10'h0a0, 8'h1b);
      get(10'h0a4, 8'hd5);
      frame(1'b0, 8'h40);
      get(10'h0a4, 8'hd5);
      frame(1'b1, 8'h9b);
      get(10'h0a0, 8'h9b);
      get(10'h0a4, 8'h40);
   end
   endtask
   task t_tx;
   begin
      bus(1'b1, 10'h080, 32'h9b);
      bus(1'b1, 10'h084, 32'h65);
      frame(1'b1, 8'h00);
      check(txw, 8'h9b);
      frame(1'b0, 8'h00);
      check(txw, 8'h65);
      bus(1'b1, 10'h084, 32'h4a);
      frame(1'b0, 8'h00);
      check(txw, 8'h65);
      frame(1'b1, 8'h00);
      frame(1'b0, 8'h00);
      check(txw, 8'h4a);
   end
   endtask
   task t_ovr;
   begin
      for (k = 0; k < 8; k = k + 1)
      begin
         c = 8'h01 << k;
         bus(1'b1, 10'h0c0, {24'h0, c});
         si <= 1'b0;
         frame(1'b1, 8'h00);
         check(txw, {~|c[2:0], 7'h1b});
         si <= 1'b1;
         frame(1'b0, 8'h00);
         check(txw, {|c[2:0], 2'h2, |c[7:3] ? 5'h1f : 5'h0a});
      end
      bus(1'b1, 10'h0c0, 32'h0);
   end
   endtask
   task t_irq;
   begin
      bus(1'b1, 10'h0c8, 32'h3);
      bus(1'b1, 10'h0cc, 32'h3);
      irq_is(1'b0);
      frame(1'b1, 8'h00);
      irq_is(1'b1);
      bus(1'b1, 10'h0cc, 32'h0);
      irq_is(1'b0);
      bus(1'b1, 10'h0c8, 32'h1);
      bus(1'b1, 10'h0cc, 32'h2);
      irq_is(1'b1);
      bus(1'b1, 10'h0c8, 32'h2);
      irq_is(1'b0);
      get(10'h0c4, 8'h00);
   end
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs;
      t_rx;
      t_tx;
      t_ovr;
      t_irq;
      conclude;
   end
endmodule // testbench
`default_nettype wire
